// ### rtl/spc_pkg.sv
package spc_pkg;
    localparam int unsigned SPC_WORD_W      = 16;
    localparam int unsigned SPC_CNT_W       = 4;
    localparam logic [7:0]  SPC_OFF_STATUS  = 8'h00;
    localparam logic [7:0]  SPC_OFF_CONTROL = 8'h04;
    localparam logic [7:0]  SPC_OFF_BUFFER  = 8'h08;
    localparam int unsigned SPC_BIT_ENABLE  = 15;
    localparam int unsigned SPC_BIT_IDLE    = 13;
    localparam int unsigned SPC_BIT_ROV     = 6;
    localparam int unsigned SPC_BIT_TBF     = 1;
    localparam int unsigned SPC_BIT_RBF     = 0;
    localparam int unsigned SPC_BIT_MASTER  = 0;
    localparam logic        SPC_RST_FLAG    = 1'b0;
    localparam logic [15:0] SPC_RST_WORD    = 16'h0000;
    localparam logic [1:0]  SPC_HTRANS_NSEQ = 2'h2;
    localparam logic [1:0]  SPC_HTRANS_SEQ  = 2'h3;
    localparam int unsigned SPC_HALF_DIV    = 2;
    typedef enum logic [0:0] {SPC_M_IDLE, SPC_M_SHIFT} spc_mstate_e;
endpackage

// ### rtl/spc_port_core.sv
// Overview of operation
// - sixteen-bit shift register moves words to and from the software buffer
// - master mode drives the shift clock and makes every edge
// - slave mode takes the shift clock in; the far master clocks it
// - select input is active low; high deselects the slave
// - one pin carries serial data in, another serial data out
// - enable bit 15 of status enables port and claims the pins
// - word arriving with buffer unread is dropped and sets overflow flag
// - transmit full flag stands while a written word awaits start
// - idle-stop bit halts the port while the processor idles
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spc_port_core #(
    parameter int unsigned HALF_DIV = spc_pkg::SPC_HALF_DIV
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cpu_idle,
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    input  wire logic        select_n_pin
);
    import spc_pkg::*;

    // two low-phase cycles let the synchronised data in settle before the sampling edge
    if (HALF_DIV < 2 || HALF_DIV > 255) begin
        $error("HALF_DIV must lie in 2..255");
    end

    typedef struct packed {
        logic        en;
        logic        idle_stop;
        logic        master;
        logic        rov;
        logic        rbf;
        logic        tbf;
        logic [15:0] hold;
        logic [15:0] rxbuf;
        logic [15:0] txw;
        logic [15:0] sr;
        spc_mstate_e st;
        logic [7:0]  div;
        logic [4:0]  bits;
        logic        sck;
        logic        sel_s1;
        logic        sel_s2;
        logic        sdi_s1;
        logic        sdi_s2;
        logic        tg_s1;
        logic        tg_s2;
        logic        tg_s3;
        logic        wr_pend;
        logic [7:0]  waddr;
        logic [31:0] rdata;
    } spc_h_s;

    typedef struct packed {
        logic [3:0]  cnt;
        logic [15:0] sr;
    } spc_lk_s;

    typedef struct packed {
        logic [15:0] word;
        logic        tgl;
    } spc_lw_s;

    spc_h_s  h_q;
    spc_h_s  h_d;
    spc_lk_s lk_q;
    spc_lk_s lk_d;
    spc_lw_s lw_q;
    spc_lw_s lw_d;
    logic    link_rst_n;
    logic    addr_ok;
    logic    halted;
    logic    slave_on;
    logic    rx_evt;
    logic [15:0] rx_word;
    logic [15:0] shifted;

    // link side: slave shifting on the incoming shift clock
    // deselect mid-word clears the partial count
    assign link_rst_n = hresetn & ~select_n_pin;

    always_comb begin
        lk_d = lk_q;
        lw_d = lw_q;
        if (lk_q.cnt == '0) begin
            lk_d.sr = {h_q.txw[14:0], serial_in_pin};
        end else begin
            lk_d.sr = {lk_q.sr[14:0], serial_in_pin};
        end
        lk_d.cnt = lk_q.cnt + 4'h1;
        if (lk_q.cnt == 4'hF) begin
            lw_d.word = lk_d.sr;
            lw_d.tgl  = ~lw_q.tgl;
        end
    end

    always_ff @(posedge shift_clock_pin_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    always_ff @(posedge shift_clock_pin_i or negedge hresetn) begin
        if (!hresetn) begin
            lw_q <= '0;
        end else begin
            lw_q <= lw_d;
        end
    end

    // bus side
    assign halted   = h_q.idle_stop & cpu_idle;
    assign slave_on = h_q.en & ~h_q.master & ~halted;
    assign addr_ok  = hsel & hready & (htrans == SPC_HTRANS_NSEQ || htrans == SPC_HTRANS_SEQ);
    assign shifted  = {h_q.sr[14:0], h_q.sdi_s2};

    always_comb begin
        h_d        = h_q;
        rx_evt     = 1'b0;
        rx_word    = h_q.sr;
        h_d.sel_s1 = select_n_pin;
        h_d.sel_s2 = h_q.sel_s1;
        h_d.sdi_s1 = serial_in_pin;
        h_d.sdi_s2 = h_q.sdi_s1;
        h_d.tg_s1  = lw_q.tgl;
        h_d.tg_s2  = h_q.tg_s1;
        h_d.tg_s3  = h_q.tg_s2;

        // master engine
        if (!h_q.en || !h_q.master) begin
            h_d.st   = SPC_M_IDLE;
            h_d.sck  = 1'b0;
            h_d.div  = '0;
            h_d.bits = '0;
        end else if (!halted) begin
            case (h_q.st)
                SPC_M_IDLE: begin
                    if (h_q.tbf) begin
                        h_d.sr   = h_q.hold;
                        h_d.tbf  = 1'b0;
                        h_d.st   = SPC_M_SHIFT;
                        h_d.div  = '0;
                        h_d.bits = '0;
                    end
                end
                SPC_M_SHIFT: begin
                    if (h_q.div == 8'(HALF_DIV - 1)) begin
                        h_d.div = '0;
                        h_d.sck = ~h_q.sck;
                        if (!h_q.sck) begin
                            h_d.sr   = shifted;
                            h_d.bits = h_q.bits + 5'h01;
                        end else if (h_q.bits == 5'h10) begin
                            h_d.sck = 1'b0;
                            h_d.st  = SPC_M_IDLE;
                            rx_evt  = 1'b1;
                        end
                    end else begin
                        h_d.div = h_q.div + 8'h01;
                    end
                end
                default: begin
                    h_d.st = SPC_M_IDLE;
                end
            endcase
        end

        // slave: hand next word to the link while deselected or after a word
        if (slave_on && h_q.tbf && (h_q.sel_s2 || (h_q.tg_s2 != h_q.tg_s3))) begin
            h_d.txw = h_q.hold;
            h_d.tbf = 1'b0;
        end
        if (slave_on && (h_q.tg_s2 != h_q.tg_s3)) begin
            rx_evt  = 1'b1;
            rx_word = lw_q.word;
        end

        // bus read in address phase; buffer read clears full flag
        h_d.wr_pend = 1'b0;
        if (addr_ok) begin
            h_d.rdata = '0;
            if (hwrite) begin
                h_d.wr_pend = 1'b1;
                h_d.waddr   = haddr[7:0];
            end else begin
                case (haddr[7:0])
                    SPC_OFF_STATUS: begin
                        h_d.rdata[SPC_BIT_ENABLE] = h_q.en;
                        h_d.rdata[SPC_BIT_IDLE]   = h_q.idle_stop;
                        h_d.rdata[SPC_BIT_ROV]    = h_q.rov;
                        h_d.rdata[SPC_BIT_TBF]    = h_q.tbf;
                        h_d.rdata[SPC_BIT_RBF]    = h_q.rbf;
                    end
                    SPC_OFF_CONTROL: begin
                        h_d.rdata[SPC_BIT_MASTER] = h_q.master;
                    end
                    SPC_OFF_BUFFER: begin
                        h_d.rdata[15:0] = h_q.rxbuf;
                        h_d.rbf         = 1'b0;
                    end
                    default: begin
                        h_d.rdata = '0;
                    end
                endcase
            end
        end

        // bus write in data phase
        if (h_q.wr_pend) begin
            case (h_q.waddr)
                SPC_OFF_STATUS: begin
                    h_d.en        = hwdata[SPC_BIT_ENABLE];
                    h_d.idle_stop = hwdata[SPC_BIT_IDLE];
                    if (!hwdata[SPC_BIT_ROV]) begin
                        h_d.rov = 1'b0;
                    end
                end
                SPC_OFF_CONTROL: begin
                    h_d.master = hwdata[SPC_BIT_MASTER];
                end
                SPC_OFF_BUFFER: begin
                    h_d.hold = hwdata[15:0];
                    h_d.tbf  = 1'b1;
                end
                default: begin
                    h_d.master = h_q.master;
                end
            endcase
        end

        // arrival: set wins over a clear in the same cycle
        if (rx_evt) begin
            if (h_q.rbf) begin
                h_d.rov = 1'b1;
            end else begin
                h_d.rxbuf = rx_word;
                h_d.rbf   = 1'b1;
            end
        end

        if (!h_q.en) begin
            h_d.tbf = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            h_q        <= '0;
            h_q.rov    <= SPC_RST_FLAG;
            h_q.rbf    <= SPC_RST_FLAG;
            h_q.tbf    <= SPC_RST_FLAG;
            h_q.hold   <= SPC_RST_WORD;
            h_q.rxbuf  <= SPC_RST_WORD;
            h_q.txw    <= SPC_RST_WORD;
            h_q.st     <= SPC_M_IDLE;
            h_q.sel_s1 <= 1'b1;
            h_q.sel_s2 <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    // pins
    assign hrdata             = h_q.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign shift_clock_pin_o  = h_q.sck;
    assign shift_clock_pin_oe = h_q.en & h_q.master;
    // slave shows the held word until the first link edge
    always_comb begin
        if (h_q.master) begin
            serial_out_pin_o = h_q.sr[15];
        end else if (lk_q.cnt == '0) begin
            serial_out_pin_o = h_q.txw[15];
        end else begin
            serial_out_pin_o = lk_q.sr[15];
        end
    end
    assign serial_out_pin_oe  = h_q.en & (h_q.master | ~select_n_pin);
endmodule
`default_nettype wire

// ### bench/spc_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spc_port_monitor #(
    parameter int unsigned HALF_DIV = 2
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe,
    input wire logic        serial_out_pin_o,
    input wire logic        serial_out_pin_oe,
    input wire logic        select_n_pin
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence sck_high_phase;
        ##HALF_DIV $fell(shift_clock_pin_o);
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stalled or error");
    reset_idle_a: assert property (
        $rose(hresetn) |-> !shift_clock_pin_o && !shift_clock_pin_oe && !serial_out_pin_oe && hrdata == 32'h0)
        else $error("outputs not idle after reset");
    master_drives_a: assert property (shift_clock_pin_oe |-> serial_out_pin_oe)
        else $error("master without data out");
    sck_owner_a: assert property ($changed(shift_clock_pin_o) |-> $past(shift_clock_pin_oe))
        else $error("shift clock moved while not master");
    sck_pulse_a: assert property ($rose(shift_clock_pin_o) |-> sck_high_phase)
        else $error("shift clock high phase wrong");
    sdo_steady_a: assert property (
        shift_clock_pin_oe && shift_clock_pin_o && $past(shift_clock_pin_o) |-> $stable(serial_out_pin_o))
        else $error("data out moved while clock high");
    deselect_off_a: assert property (
        (select_n_pin && !shift_clock_pin_oe) [*3] |-> !serial_out_pin_oe)
        else $error("deselected slave drives data out");
    select_low_a: assert property (
        serial_out_pin_oe |-> shift_clock_pin_oe || $past(shift_clock_pin_oe) || !select_n_pin || !$past(select_n_pin))
        else $error("slave drives data out unselected");
endmodule
bind spc_port_core spc_port_monitor #(.HALF_DIV(HALF_DIV)) mon_u (.hclk, .hresetn, .hrdata, .hreadyout, .hresp,
    .shift_clock_pin_o, .shift_clock_pin_oe, .serial_out_pin_o, .serial_out_pin_oe, .select_n_pin);
`default_nettype wire

// ### bench/spc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module spc_far_end (
    input  wire logic dut_master,
    input  wire logic sck_o,
    input  wire logic sdo,
    output logic      sdi,
    output logic      sck,
    output logic      sel_n
);
    logic [15:0] tx_w = 16'h0000;
    logic [15:0] rx_w = 16'h0000;
    logic        sdo_d = 1'b1;
    always @(sdo) sdo_d <= #1 sdo;
    initial begin
        sdi = 1'b0;
        sck = 1'b0;
        sel_n = 1'b1;
    end
    task automatic load(input logic [15:0] w);
        tx_w = w;
        sdi = w[15];
    endtask
    always @(posedge sck_o) if (dut_master) begin
        tx_w <= {tx_w[14:0], ~tx_w[0]};
        sdi <= tx_w[14];
    end
    always @(posedge sck_o) if (dut_master) rx_w <= {rx_w[14:0], sdo_d};
    task automatic xfer(input logic [15:0] w);
        load(w);
        sel_n = 1'b0;
        #15;
        repeat (16) begin
            rx_w = {rx_w[14:0], sdo};
            sck = 1'b1;
            #7.5;
            sck = 1'b0;
            tx_w = {tx_w[14:0], ~tx_w[0]};
            sdi = tx_w[15];
            #7.5;
        end
        sel_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/spc_port_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spc_port_core_tb;
    import spc_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic        hsel = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic        cpu_idle = 1'b0;
    logic        mst = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, sck_o, sck_oe, sdo_o, sdo_oe, sck_i, sdi, sel_n;
    int          err_count = 0, samples_checked = 0, cycles = 0, rises = 0;
    spc_port_core #(.HALF_DIV(2)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cpu_idle, .shift_clock_pin_i(sck_i),
        .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .serial_in_pin(sdi), .serial_out_pin_o(sdo_o),
        .serial_out_pin_oe(sdo_oe), .select_n_pin(sel_n));
    spc_far_end far_u (.dut_master(mst), .sck_o(sck_o), .sdo(sdo_oe ? sdo_o : 1'b1), .sdi(sdi), .sck(sck_i),
        .sel_n(sel_n));
    initial begin
        forever #20 hclk = ~hclk;
    end
    always @(posedge sck_o) rises++;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        hsize <= 3'h2;
        htrans <= SPC_HTRANS_NSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic wait_bit(input int b);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 300 && r[b] !== 1'b1; i++) bus(1'b0, SPC_OFF_STATUS, 32'h0, r);
        if (r[b] !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t status bit %0d never set", $time, b);
        end
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(SPC_OFF_STATUS, 32'h0);
        rd(SPC_OFF_CONTROL, 32'h0);
        rd(SPC_OFF_BUFFER, 32'h0);
        wr(8'h0C, 32'hFFFF);
        rd(8'h0C, 32'h0);
        $display("reset test done");
        mst <= 1'b1;
        far_u.load(16'hA5C3);
        wr(SPC_OFF_CONTROL, 32'h1);
        cpu_idle <= 1'b1;
        wr(SPC_OFF_STATUS, 32'hA000);
        @(posedge hclk);
        chk({31'h0, sck_oe}, 32'h1);
        wr(SPC_OFF_BUFFER, 32'h3C96);
        repeat (20) @(posedge hclk);
        rd(SPC_OFF_STATUS, 32'hA002);
        chk(32'(rises), 32'h0);
        cpu_idle <= 1'b0;
        wait_bit(0);
        rd(SPC_OFF_STATUS, 32'hA001);
        rd(SPC_OFF_BUFFER, 32'hA5C3);
        chk({16'h0, far_u.rx_w}, 32'h3C96);
        rd(SPC_OFF_STATUS, 32'hA000);
        $display("master test done");
        cpu_idle <= 1'b1;
        wr(SPC_OFF_STATUS, 32'h8000);
        far_u.load(16'h1234);
        wr(SPC_OFF_BUFFER, 32'h00FF);
        wait_bit(0);
        far_u.load(16'h5678);
        wr(SPC_OFF_BUFFER, 32'hFF00);
        wait_bit(6);
        rd(SPC_OFF_STATUS, 32'h8041);
        rd(SPC_OFF_BUFFER, 32'h1234);
        wr(SPC_OFF_STATUS, 32'h8000);
        rd(SPC_OFF_STATUS, 32'h8000);
        $display("overflow test done");
        mst <= 1'b0;
        wr(SPC_OFF_CONTROL, 32'h0);
        @(posedge hclk);
        chk({31'h0, sck_oe}, 32'h0);
        wr(SPC_OFF_BUFFER, 32'hC3A5);
        repeat (8) @(posedge hclk);
        far_u.xfer(16'h6E19);
        @(posedge hclk);
        wait_bit(0);
        rd(SPC_OFF_BUFFER, 32'h6E19);
        chk({16'h0, far_u.rx_w}, 32'hC3A5);
        chk({31'h0, sdo_oe}, 32'h0);
        $display("slave test done");
        wr(SPC_OFF_CONTROL, 32'h1);
        wr(SPC_OFF_STATUS, 32'h0);
        repeat (2) @(posedge hclk);
        chk({30'h0, sck_oe, sdo_oe}, 32'h0);
        $display("disable test done");
        print_verdict();
    end
endmodule
`default_nettype wire
